// ### hw/meter_event_status_flags.sv
// Purpose: event status flag register with reset-complete and masked interrupt pin
// Assumes: event inputs come from logic on clk; pulses are one cycle
// Notes: bit 21 reads one, bit 22 and bits above 23 read zero
//
// Operation
// - total-power no-load sets bit 0, phase 2:0
// - fundamental no-load sets bit 1, phase 5:3
// - apparent no-load sets bit 2, phase 8:6
// - missing voltage crossing sets bits 3-5
// - missing current crossing sets bits 6-8
// - voltage crossing seen sets bits 9-11
// - current crossing seen sets bits 12-14
// - reset-complete bit 15 set after reset ends
// - reset-complete drives interrupt pin low, unmaskable
// - config bit 7 write starts software reset
// - sag enter or exit sets bit 16
// - overcurrent sets bit 17, phase 5:3
// - overvoltage sets bit 18, phase 11:9
// - A then C rising sets bit 19
// - current mismatch above threshold sets bit 20
// - bit 21 always reads one
// - bit 22 always reads zero
// - peak period end sets bit 23, latches peak
`timescale 1ns/1ps
`default_nettype none

module meter_event_status_flags #(
  parameter int RESET_CYCLES = meter_flags_pkg::RESET_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire meter_flags_pkg::bus_req_s bus,
  input wire meter_flags_pkg::events_s evt,
  input wire logic pm_to_normal,
  output logic [meter_flags_pkg::DATA_W-1:0] rdata,
  output logic interrupt_pin_one_b
);
  import meter_flags_pkg::*;

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << CNT_W)) begin : g_bad_reset_cycles
    $error("RESET_CYCLES out of range");
  end

  localparam logic [CNT_W-1:0] RST_LOAD = CNT_W'(RESET_CYCLES);

  localparam flags_state_s STATE_DEFAULT = '{
    status: STATUS_RESET,
    mask: MASK_RESET,
    noload_phase: 9'h000,
    phase_status: 15'h0000,
    sag_prev: 3'h0,
    mismatch_lvl: MISMATCH_LVL_RESET,
    peak: 32'h00000000,
    seq: seq_idle,
    rst_cnt: RST_LOAD,
    rdata: 32'h00000000,
    irq_b: 1'b1
  };

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SMP_W-1:0] magnitude(input logic [SMP_W-1:0] v);
    logic [SMP_W-1:0] r;
    r = v[SMP_W-1] ? SMP_W'(~v + 1'b1) : v;
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                 input flags_state_s st);
    logic [DATA_W-1:0] r;
    r = '0;
    case (a)
      ADDR_STATUS: r = (st.status & STATUS_W1C_MASK) | STATUS_ONE_MASK;
      ADDR_MASK: r = st.mask;
      ADDR_NOLOAD_PH: r = {23'h000000, st.noload_phase};
      ADDR_PH_STATUS: r = {17'h00000, st.phase_status};
      ADDR_MISMATCH_LVL: r = {8'h00, st.mismatch_lvl};
      ADDR_PEAK: r = st.peak;
      default: r = '0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  flags_state_s state_reg;
  flags_state_s state_next;
  logic [DATA_W-1:0] set_bits;
  logic [DATA_W-1:0] clr_bits;
  logic [SMP_W-1:0] mag_sum;
  logic [SMP_W-1:0] mag_neutral;
  logic [SMP_W-1:0] mag_diff;
  logic sw_reset;
  logic busy;
  logic wr_status;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.rdata = '0;
    set_bits = '0;
    clr_bits = '0;
    busy = (state_reg.rst_cnt != '0);
    sw_reset = bus.wr && (bus.addr == ADDR_CONFIG) && bus.wdata[CFG_SW_RESET_BIT];
    wr_status = bus.wr && (bus.addr == ADDR_STATUS);
    mag_sum = magnitude(evt.summed_phase_current);
    mag_neutral = magnitude(evt.neutral_current_sample);
    mag_diff = (mag_sum > mag_neutral) ? SMP_W'(mag_sum - mag_neutral)
                                       : SMP_W'(mag_neutral - mag_sum);

    if (busy) begin
      // registers sit at defaults until the countdown ends
      state_next = STATE_DEFAULT;
      state_next.rst_cnt = CNT_W'(state_reg.rst_cnt - 1'b1);
      if (state_reg.rst_cnt == CNT_W'(1)) begin
        state_next.status[BIT_RESET_DONE] = 1'b1;
      end
    end else if (sw_reset || pm_to_normal) begin
      state_next = STATE_DEFAULT;
    end else begin
      // no-load: flag on any phase entering, phase field mirrors level
      if ((evt.noload_total & ~state_reg.noload_phase[NL_TOTAL_POS +: 3]) != 3'h0) begin
        set_bits[BIT_TOTAL_NOLOAD] = 1'b1;
      end
      if ((evt.noload_fund & ~state_reg.noload_phase[NL_FUND_POS +: 3]) != 3'h0) begin
        set_bits[BIT_FUND_NOLOAD] = 1'b1;
      end
      if ((evt.noload_app & ~state_reg.noload_phase[NL_APP_POS +: 3]) != 3'h0) begin
        set_bits[BIT_APP_NOLOAD] = 1'b1;
      end
      state_next.noload_phase[NL_TOTAL_POS +: 3] = evt.noload_total;
      state_next.noload_phase[NL_FUND_POS +: 3] = evt.noload_fund;
      state_next.noload_phase[NL_APP_POS +: 3] = evt.noload_app;

      // zero crossings
      set_bits[BIT_VOLT_TIMEOUT +: 3] = evt.volt_timeout;
      set_bits[BIT_CURR_TIMEOUT +: 3] = evt.curr_timeout;
      set_bits[BIT_VOLT_CROSS +: 3] = evt.volt_cross;
      set_bits[BIT_CURR_CROSS +: 3] = evt.curr_cross;

      // sag entry or exit
      state_next.sag_prev = evt.sag_level;
      if (evt.sag_level != state_reg.sag_prev) begin
        set_bits[BIT_SAG] = 1'b1;
        state_next.phase_status[PH_SAG_POS +: 3] = evt.sag_level ^ state_reg.sag_prev;
      end

      // overcurrent and overvoltage
      if (evt.oi_event) begin
        set_bits[BIT_OVERCURRENT] = 1'b1;
        state_next.phase_status[PH_OI_POS +: 3] = evt.oi_phase;
      end
      if (evt.ov_event) begin
        set_bits[BIT_OVERVOLTAGE] = 1'b1;
        state_next.phase_status[PH_OV_POS +: 3] = evt.ov_phase;
      end

      // phase order: after a rising A, the next rising must be B
      case (state_reg.seq)
        seq_idle: begin
          if (evt.volt_rise[0]) begin
            state_next.seq = seq_after_a;
          end
        end
        seq_after_a: begin
          if (evt.volt_rise[2] && !evt.volt_rise[1]) begin
            set_bits[BIT_PHASE_ORDER] = 1'b1;
            state_next.seq = seq_idle;
          end else if (evt.volt_rise[1]) begin
            state_next.seq = seq_idle;
          end
        end
        default: begin
          state_next.seq = seq_idle;
        end
      endcase

      // neutral current mismatch
      if (evt.sum_valid && (mag_diff > state_reg.mismatch_lvl)) begin
        set_bits[BIT_MISMATCH] = 1'b1;
      end

      // current peak period end
      if (evt.peak_done) begin
        set_bits[BIT_PEAK_DONE] = 1'b1;
        state_next.peak = '0;
        state_next.peak[SMP_W-1:0] = evt.peak_value;
        state_next.peak[PEAK_PHASE_POS +: 3] = evt.peak_phase;
      end

      // register writes
      if (wr_status) begin
        clr_bits = bus.wdata & STATUS_W1C_MASK;
      end
      if (bus.wr && bus.addr == ADDR_MASK) begin
        state_next.mask = bus.wdata & STATUS_W1C_MASK;
      end
      if (bus.wr && bus.addr == ADDR_MISMATCH_LVL) begin
        state_next.mismatch_lvl = bus.wdata[SMP_W-1:0];
      end

      // set wins over a clear in the same cycle
      state_next.status = ((state_reg.status & ~clr_bits) | set_bits) & STATUS_W1C_MASK;
    end

    // reads answer one cycle later, zero otherwise
    if (bus.rd) begin
      state_next.rdata = read_mux(bus.addr, state_reg);
    end

    // interrupt pin from the next flag state
    state_next.irq_b = !(state_next.status[BIT_RESET_DONE] ||
                         ((state_next.status & state_next.mask) != '0));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= STATE_DEFAULT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = state_reg.rdata;
  assign interrupt_pin_one_b = state_reg.irq_b;

endmodule

`default_nettype wire

// ### hw/meter_flags_pkg.sv
// Purpose: constants, carriers and state types of the event status flag block
// Assumes: registers reached over a plain address/strobe port
// Notes: status bits above 23 and the event computations live elsewhere
`default_nettype none
package meter_flags_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int SMP_W = 24;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'he503;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 16'he50b;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 16'he618;
  localparam logic [ADDR_W-1:0] ADDR_NOLOAD_PH = 16'he608;
  localparam logic [ADDR_W-1:0] ADDR_PH_STATUS = 16'he600;
  localparam logic [ADDR_W-1:0] ADDR_MISMATCH_LVL = 16'he60c;
  localparam logic [ADDR_W-1:0] ADDR_PEAK = 16'he500;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_TOTAL_NOLOAD = 0;
  localparam int BIT_FUND_NOLOAD = 1;
  localparam int BIT_APP_NOLOAD = 2;
  localparam int BIT_VOLT_TIMEOUT = 3;
  localparam int BIT_CURR_TIMEOUT = 6;
  localparam int BIT_VOLT_CROSS = 9;
  localparam int BIT_CURR_CROSS = 12;
  localparam int BIT_RESET_DONE = 15;
  localparam int BIT_SAG = 16;
  localparam int BIT_OVERCURRENT = 17;
  localparam int BIT_OVERVOLTAGE = 18;
  localparam int BIT_PHASE_ORDER = 19;
  localparam int BIT_MISMATCH = 20;
  localparam int BIT_PEAK_DONE = 23;
  localparam int CFG_SW_RESET_BIT = 7;
  localparam int NL_TOTAL_POS = 0;
  localparam int NL_FUND_POS = 3;
  localparam int NL_APP_POS = 6;
  localparam int PH_OI_POS = 3;
  localparam int PH_OV_POS = 9;
  localparam int PH_SAG_POS = 12;
  localparam int PEAK_PHASE_POS = 24;

  // ----------------------------------------------------------------
  // masks and reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] STATUS_W1C_MASK = 32'h009fffff;
  localparam logic [DATA_W-1:0] STATUS_ONE_MASK = 32'h00200000;
  localparam logic [DATA_W-1:0] STATUS_RESET = 32'h00000000;
  localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;
  localparam logic [SMP_W-1:0] MISMATCH_LVL_RESET = 24'h000000;
  localparam int RESET_CYCLES_DEFAULT = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [2:0] noload_total;
    logic [2:0] noload_fund;
    logic [2:0] noload_app;
    logic [2:0] volt_timeout;
    logic [2:0] curr_timeout;
    logic [2:0] volt_cross;
    logic [2:0] curr_cross;
    logic [2:0] volt_rise;
    logic [2:0] sag_level;
    logic oi_event;
    logic [2:0] oi_phase;
    logic ov_event;
    logic [2:0] ov_phase;
    logic sum_valid;
    logic [SMP_W-1:0] summed_phase_current;
    logic [SMP_W-1:0] neutral_current_sample;
    logic peak_done;
    logic [2:0] peak_phase;
    logic [SMP_W-1:0] peak_value;
  } events_s;

  typedef enum logic {
    seq_idle,
    seq_after_a
  } seq_e;

  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] mask;
    logic [8:0] noload_phase;
    logic [14:0] phase_status;
    logic [2:0] sag_prev;
    logic [SMP_W-1:0] mismatch_lvl;
    logic [DATA_W-1:0] peak;
    seq_e seq;
    logic [CNT_W-1:0] rst_cnt;
    logic [DATA_W-1:0] rdata;
    logic irq_b;
  } flags_state_s;

endpackage

`default_nettype wire

// ### testbench/host_model.sv
// Purpose: host side of the register port
// Assumes: one strobe a cycle, read data one cycle later
// Notes: tasks are called from the bench
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic [meter_flags_pkg::DATA_W-1:0] rdata,
  output var meter_flags_pkg::bus_req_s bus
);
  import meter_flags_pkg::*;
  initial bus = '0;
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
    @(posedge clk) bus <= {a, v, 1'b1, 1'b0};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk) bus <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge clk) bus <= '0;
    #1 v = rdata;
  endtask
endmodule
`default_nettype wire

// ### testbench/meter_event_status_flags_bench.sv
// Purpose: self-checking bench of the event status flag block
// Assumes: countdown shortened to 2 cycles
// Notes: model holds status, mask and phase status
`timescale 1ns/1ps
`default_nettype none
module meter_event_status_flags_bench;
  import meter_flags_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pm = 1'b0;
  logic pin_b;
  events_s evt = '0;
  events_s e;
  bus_req_s bus;
  logic [31:0] rdata, d, r, w;
  logic [31:0] m_st = '0, m_mk = '0, m_ph = '0, x = 32'h0000792a;
  int fail_count = 0, compares = 0;
  meter_event_status_flags #(.RESET_CYCLES(2)) dut (.clk(clk), .rst_b(rst_b), .bus(bus),
    .evt(evt), .pm_to_normal(pm), .rdata(rdata), .interrupt_pin_one_b(pin_b));
  host_model host (.clk(clk), .rdata(rdata), .bus(bus));
  initial begin
    forever #5 clk = ~clk;
  end
  // ------
  // tasks
  // ------
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic cmp(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(logic [15:0] a, logic [31:0] exp);
    host.rd(a, d);
    cmp(d, exp);
  endtask
  task automatic st_chk();
    rd_chk(ADDR_STATUS, m_st | STATUS_ONE_MASK);
    cmp({31'h0, pin_b}, {31'h0, !(m_st[15] || |(m_st & m_mk & STATUS_W1C_MASK))});
  endtask
  task automatic ev(events_s v, logic [31:0] b);
    @(posedge clk) evt <= v;
    @(posedge clk) evt <= '0;
    m_st |= b;
  endtask
  task automatic clr();
    host.wr(ADDR_STATUS, 32'hffffffff);
    m_st = '0;
    st_chk();
  endtask
  task automatic rs_chk();
    repeat (4) @(posedge clk);
    m_st = 32'h00008000;
    m_mk = '0;
    m_ph = '0;
    st_chk();
    rd_chk(ADDR_PH_STATUS, m_ph);
  endtask
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    rs_chk();
    host.wr(ADDR_STATUS, 32'h0);
    st_chk();
    clr();
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      host.wr(ADDR_MASK, r);
      m_mk = r;
      r = rnd();
      e = '0;
      {e.ov_phase, e.ov_event, e.oi_phase, e.oi_event} = r[19:12];
      {e.curr_cross, e.volt_cross, e.curr_timeout, e.volt_timeout} = r[11:0];
      ev(e, {13'h0, r[16], r[12], 2'h0, r[11:0], 3'h0});
      if (r[12]) m_ph[5:3] = r[15:13];
      if (r[16]) m_ph[11:9] = r[19:17];
      rd_chk(ADDR_PH_STATUS, m_ph);
      st_chk();
      w = rnd();
      host.wr(ADDR_STATUS, w);
      m_st &= ~w;
      st_chk();
    end
    clr();
    e = '0;
    {e.noload_app, e.noload_fund, e.noload_total} = 9'h111;
    ev(e, 32'h00000007);
    @(posedge clk) evt <= e;
    rd_chk(ADDR_NOLOAD_PH, 32'h00000111);
    @(posedge clk) evt <= '0;
    e = '0;
    e.sag_level = 3'h4;
    ev(e, 32'h00010000);
    m_ph[14:12] = 3'h4;
    rd_chk(ADDR_PH_STATUS, m_ph);
    e = '0;
    e.volt_rise = 3'h1;
    ev(e, 32'h0);
    e.volt_rise = 3'h4;
    ev(e, 32'h00080000);
    host.wr(ADDR_MISMATCH_LVL, 32'h00000032);
    e = '0;
    e.sum_valid = 1'b1;
    e.summed_phase_current = 24'h000032;
    ev(e, 32'h0);
    e.summed_phase_current = 24'h000064;
    e.neutral_current_sample = 24'hfffff6;
    ev(e, 32'h00100000);
    e = '0;
    {e.peak_done, e.peak_phase, e.peak_value} = {4'ha, 24'h123456};
    ev(e, 32'h00800000);
    rd_chk(ADDR_PEAK, 32'h02123456);
    st_chk();
    rd_chk(16'h0000, 32'h0);
    host.wr(ADDR_CONFIG, 32'h00000080);
    rs_chk();
    @(posedge clk) pm <= 1'b1;
    @(posedge clk) pm <= 1'b0;
    rs_chk();
    print_verdict();
  end
endmodule
`default_nettype wire

// ### testbench/meter_flags_sva.sv
// Purpose: port assertions of the event status flag block
// Assumes: events and writes only after the reset countdown
// Notes: bound into the block below
`timescale 1ns/1ps
`default_nettype none
module meter_flags_sva
  import meter_flags_pkg::*;
#(
  parameter int RESET_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire meter_flags_pkg::bus_req_s bus,
  input wire meter_flags_pkg::events_s evt,
  input wire logic pm_to_normal,
  input wire logic [meter_flags_pkg::DATA_W-1:0] rdata,
  input wire logic interrupt_pin_one_b
);
  // ------
  // properties
  // ------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_one21;
    bus.rd && bus.addr == ADDR_STATUS |=> rdata[21];
  endproperty
  a_one21: assert property (p_one21) else $error("bit 21 low");
  property p_zero22;
    bus.rd && bus.addr == ADDR_STATUS |=> !rdata[22] && rdata[31:24] == '0;
  endproperty
  a_zero22: assert property (p_zero22) else $error("bit 22 high");
  property p_pm;
    pm_to_normal |=> interrupt_pin_one_b ##[1:300] !interrupt_pin_one_b;
  endproperty
  a_pm: assert property (p_pm) else $error("no reset done after power mode");
  property p_swr;
    bus.wr && bus.addr == ADDR_CONFIG && bus.wdata[7]
      |=> interrupt_pin_one_b ##[1:300] !interrupt_pin_one_b;
  endproperty
  a_swr: assert property (p_swr) else $error("no reset done after sw reset");
  property p_oi;
    evt.oi_event ##2 bus.rd && bus.addr == ADDR_PH_STATUS && !$past(evt.oi_event)
      |=> rdata[5:3] == $past(evt.oi_phase, 3);
  endproperty
  a_oi: assert property (p_oi) else $error("overcurrent phase");
  property p_ov;
    evt.ov_event ##2 bus.rd && bus.addr == ADDR_PH_STATUS && !$past(evt.ov_event)
      |=> rdata[11:9] == $past(evt.ov_phase, 3);
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage phase");
  property p_pk;
    evt.peak_done ##2 bus.rd && bus.addr == ADDR_PEAK && !$past(evt.peak_done)
      |=> rdata[26:0] == {$past(evt.peak_phase, 3), $past(evt.peak_value, 3)};
  endproperty
  a_pk: assert property (p_pk) else $error("peak register");
  property p_zx;
    evt.volt_cross[0] ##1 (!bus.wr && !pm_to_normal)[*4]
      ##1 bus.rd && bus.addr == ADDR_STATUS |=> rdata[9];
  endproperty
  a_zx: assert property (p_zx) else $error("crossing flag");
  property p_clr;
    bus.wr && bus.addr == ADDR_STATUS && &bus.wdata && evt == '0 ##1 evt == '0
      ##1 bus.rd && bus.addr == ADDR_STATUS && evt == '0 |=> rdata == STATUS_ONE_MASK;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
endmodule
bind meter_event_status_flags meter_flags_sva #(.RESET_CYCLES(RESET_CYCLES)) chk (
  .clk(clk), .rst_b(rst_b), .bus(bus), .evt(evt), .pm_to_normal(pm_to_normal),
  .rdata(rdata), .interrupt_pin_one_b(interrupt_pin_one_b));
`default_nettype wire
